/* hdl/loop_ctl_defs.svh */
/*
  Offsets, field positions, code ranges and timing counts of the loop mode controller.
  Assumes a 40 MHz reference clock and 16-bit register words.
*/
`ifndef LOOP_CTL_DEFS_SVH
`define LOOP_CTL_DEFS_SVH
// ==========================================================================
// Timing
`define REF_CLK_KHZ 40000
`define HIST_SAMPLE_MS 1000
`define HIST_SPAN_S 120
`define HIST_TICK_CYC (`HIST_SAMPLE_MS * `REF_CLK_KHZ)
`define RAMP_TICK_US 1
`define RAMP_TICK_CYC ((`RAMP_TICK_US * `REF_CLK_KHZ) / 1000)
// ==========================================================================
// Register offsets
`define REG_CTRL 3'h0
`define REG_BW 3'h1
`define REG_HOLD 3'h2
`define REG_RAMP 3'h3
`define REG_STATUS 3'h4
`define REG_FREQ_LO 3'h5
`define REG_FREQ_HI 3'h6
`define NVM_WORDS 3'h4
// ==========================================================================
// Field positions
`define CTRL_FAST_BIT 0
`define CTRL_RAMP_BIT 1
`define CTRL_HOSEL_BIT 2
`define CTRL_SOFT_BIT 3
`define CTRL_HARD_BIT 4
`define BW_NORM_LSB 0
`define BW_FAST_LSB 4
`define BW_HOEX_LSB 8
`define HOLD_DELAY_LSB 0
`define HOLD_WIN_LSB 6
`define STAT_LOL_BIT 3
`define STAT_HIST_BIT 4
`define STAT_INIT_BIT 5
// ==========================================================================
// Code ranges
`define BW_1HZ 4'h0
`define BW_20HZ 4'h3
`define BW_100HZ 4'h5
`define BW_4KHZ 4'hc
`define RAMP_CODE_MAX 6'h27
`define WIN_LOG2_MAX 3'h6
`endif

/* hdl/loop_ctl_pkg.sv */
/*
  Types of the loop mode controller: modes and the configuration image.
  Assumes loop_ctl_defs.svh for field positions.
*/
`include "loop_ctl_defs.svh"
package loop_ctl_pkg;
  // ========================================================================
  // Types
  typedef enum logic [2:0] {
    MODE_INIT = 3'b000,
    MODE_FREERUN = 3'b001,
    MODE_ACQ = 3'b010,
    MODE_LOCKED = 3'b011,
    MODE_HOLD = 3'b100,
    MODE_FREEZE = 3'b101
  } mode_t;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] bw;
    logic [15:0] hold;
    logic [15:0] ramp;
  } cfg_t;
endpackage

/* hdl/hist_if.sv */
/*
  Write and read port of the frequency history memory.
  Assumes one clock shared by both ends.
*/
interface hist_if #(
  parameter int W = 24,
  parameter int AW = 7
) ();
  logic we;
  logic [AW-1:0] waddr;
  logic [W-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [W-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* hdl/hist_mem.sv */
/*
  Frequency history store with registered read data.
  Assumes the controller drives the port from the same clock.
*/
module hist_mem #(
  parameter int W = 24,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk_i,
  hist_if.mem port
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] rdata;
  } mem_state_t;
  mem_state_t q;
  mem_state_t n;

  // ========================================================================
  // Storage
  // History is never cleared; its validity is tracked by the controller.
  always_comb
  begin
    n = q;
    n.rdata = q.mem[port.raddr];
    if (port.we)
    begin
      n.mem[port.waddr] = port.wdata;
    end
  end

  always_ff @(posedge clk_i)
  begin
    q <= n;
  end

  assign port.rdata = q.rdata;
endmodule

/* hdl/freq_ramp.sv */
/*
  Linear frequency ramp: moves the output word toward a target by one step per tick.
  Assumes tick is a one-cycle enable from a divider on the same clock.
*/
module freq_ramp #(
  parameter int W = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  input wire logic run_i,
  input wire logic [W-1:0] target_i,
  input wire logic [W-1:0] step_i,
  output logic [W-1:0] freq_o,
  output logic at_target_o
);
  typedef struct packed {
    logic [W-1:0] freq;
  } ramp_state_t;
  ramp_state_t q;
  ramp_state_t n;
  logic [W-1:0] diff;

  // ========================================================================
  // Ramp
  always_comb
  begin
    n = q;
    diff = (target_i > q.freq) ? target_i - q.freq : q.freq - target_i;
    if (load_i)
    begin
      n.freq = load_val_i;
    end
    else if (run_i && tick_i)
    begin
      if (diff <= step_i)
        n.freq = target_i;
      else if (target_i > q.freq)
        n.freq = q.freq + step_i;
      else
        n.freq = q.freq - step_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= n;
  end

  assign freq_o = q.freq;
  assign at_target_o = (q.freq == target_i);
endmodule

/* hdl/synth_loop_mode_controller.sv */
/*
  Mode controller of one digital synthesis loop: start-up load, resets, modes,
  bandwidth choice, holdover history and averaging, ramped exit, register port.
  Assumes input validity, selected input, lock detect and loop frequency come
  from logic on REF_CLK_I; the reset pin is asynchronous and is synchronised.
*/
// The plain strobed port and the register addresses were decided locally.
// Operation
// - Exactly one of five modes after start
// - Load store, no clocks or access first
// - Pin or bit hard reset reloads all
// - Soft reset applies pending configuration only
// - Freerun after start while no input valid
// - Valid input starts lock acquisition
// - Fastlock bandwidth while acquiring, then normal
// - Fastlock bandwidth 100 Hz to 4 kHz
// - Normal bandwidth 20 Hz or 1 Hz to 4 kHz
// - Locked mode reported by pin and bit
// - Input lost, history valid: enter holdover
// - Record up to 120 s history while locked
// - Average window offset by programmable delay
// - Holdover steers output to average frequency
// - Valid input leaves holdover, reacquires glitchlessly
// - Ramped exit moves frequency linearly
// - Ramp rates 0.2 to 40000 ppm/s, 40 steps
// - One ramp rate, independent of bandwidth
// - Unramped exit uses normal or exit bandwidth
// - No input, no history: VCO freeze
// - Freeze holds last frequency until input valid
// - Loss of lock flagged while unsynchronised
`include "loop_ctl_defs.svh"
module synth_loop_mode_controller #(
  parameter int unsigned HIST_TICK_CYC = `HIST_TICK_CYC,
  parameter int unsigned HIST_DEPTH = 128,
  parameter int unsigned FREQ_W = 24,
  parameter bit HIGH_FREQ_LOOP = 1'b1
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic HARD_RESET_N_PIN_I,
  output logic NVM_RD_O,
  output logic [1:0] NVM_ADDR_O,
  input wire logic [15:0] NVM_DATA_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic [3:0] INPUT_VALID_I,
  input wire logic [1:0] SEL_INPUT_I,
  input wire logic LOCK_DET_I,
  input wire logic [FREQ_W-1:0] LOOP_FREQ_I,
  output loop_ctl_pkg::mode_t LOOP_MODE_O,
  output logic [3:0] BW_CODE_O,
  output logic [FREQ_W-1:0] FREQ_WORD_O,
  output logic OUT_CLK_EN_O,
  output logic LOSS_OF_LOCK_INDICATOR_O,
  output logic HIST_VALID_O
);
  import loop_ctl_pkg::*;

  localparam int AW = $clog2(HIST_DEPTH);
  localparam int unsigned RAMP_CYC = `RAMP_TICK_CYC;

  typedef struct packed {
    mode_t mode;
    logic init_done;
    logic [2:0] nvm_idx;
    logic nvm_rd;
    logic nvm_pend;
    logic [1:0] nvm_addr;
    logic [1:0] cap_addr;
    cfg_t act;
    cfg_t pend;
    logic [15:0] rdata;
    logic [1:0] rst_sync;
    logic [AW-1:0] wptr;
    logic [AW:0] filled;
    logic hist_valid;
    logic [31:0] hist_cnt;
    logic [7:0] ramp_cnt;
    logic avg_busy;
    logic [6:0] avg_k;
    logic [FREQ_W+6:0] acc;
    logic [FREQ_W-1:0] hold_freq;
    logic ho_ramp;
    logic ho_exit;
    logic [FREQ_W-1:0] last_freq;
    logic [FREQ_W-1:0] freq_out;
    logic [3:0] bw;
    logic loss_of_lock_indicator;
  } state_t;

  state_t q;
  state_t n;
  hist_if #(.W(FREQ_W), .AW(AW)) hb ();

  logic hist_tick;
  logic ramp_tick;
  logic any_valid;
  logic sel_valid;
  logic hard_req;
  logic ramp_load;
  logic ramp_run;
  logic [FREQ_W-1:0] ramp_val;
  logic [FREQ_W-1:0] ramp_target;
  logic [FREQ_W-1:0] ramp_step;
  logic [FREQ_W-1:0] ramp_freq;
  logic ramp_done;
  logic [5:0] rate;
  logic [5:0] delay;
  logic [2:0] win;
  logic [6:0] win_n;
  logic [3:0] bw_norm;
  logic [3:0] bw_fast;
  logic [3:0] bw_hoex;
  logic [15:0] wr_word;
  logic [FREQ_W+6:0] acc_n;

  function automatic logic [3:0] clamp4(logic [3:0] v, logic [3:0] lo, logic [3:0] hi);
    if (v < lo)
      return lo;
    if (v > hi)
      return hi;
    return v;
  endfunction

  function automatic cfg_t cfg_put(cfg_t c, logic [1:0] a, logic [15:0] w);
    cfg_t r;
    r = c;
    if (a == 2'h0)
      r.ctrl = w & 16'h0007;
    else if (a == 2'h1)
      r.bw = w & 16'h0fff;
    else if (a == 2'h2)
      r.hold = w & 16'h01ff;
    else
      r.ramp = w & 16'h003f;
    return r;
  endfunction

  function automatic logic [15:0] cfg_get(cfg_t c, logic [1:0] a);
    if (a == 2'h0)
      return c.ctrl;
    if (a == 2'h1)
      return c.bw;
    if (a == 2'h2)
      return c.hold;
    return c.ramp;
  endfunction

  // ==========================================================================
  // Configuration decode
  always_comb
  begin
    rate = (q.act.ramp[5:0] > `RAMP_CODE_MAX) ? `RAMP_CODE_MAX : q.act.ramp[5:0];
    ramp_step = FREQ_W'({1'b1, rate[0]}) << rate[5:1];
    delay = q.act.hold[`HOLD_DELAY_LSB +: 6];
    win = q.act.hold[`HOLD_WIN_LSB +: 3];
    if (win > `WIN_LOG2_MAX)
      win = `WIN_LOG2_MAX;
    win_n = 7'h01 << win;
    bw_norm = clamp4(q.act.bw[`BW_NORM_LSB +: 4], HIGH_FREQ_LOOP ? `BW_20HZ : `BW_1HZ,
      `BW_4KHZ);
    bw_fast = clamp4(q.act.bw[`BW_FAST_LSB +: 4], `BW_100HZ, `BW_4KHZ);
    bw_hoex = clamp4(q.act.bw[`BW_HOEX_LSB +: 4], HIGH_FREQ_LOOP ? `BW_20HZ : `BW_1HZ,
      `BW_4KHZ);
    any_valid = |INPUT_VALID_I;
    sel_valid = INPUT_VALID_I[SEL_INPUT_I];
    hist_tick = q.init_done && (q.hist_cnt == 32'(HIST_TICK_CYC - 1));
    ramp_tick = q.init_done && (q.ramp_cnt == 8'(RAMP_CYC - 1));
    wr_word = REG_WDATA_I;
    hard_req = !q.rst_sync[1] || (q.init_done && REG_WR_I && REG_ADDR_I == `REG_CTRL &&
      wr_word[`CTRL_HARD_BIT]);
  end

  // ==========================================================================
  // History port
  always_comb
  begin
    hb.we = (q.mode == MODE_LOCKED) && sel_valid && hist_tick;
    hb.waddr = q.wptr;
    hb.wdata = LOOP_FREQ_I;
    hb.raddr = AW'(q.wptr - AW'(1) - AW'(delay) - AW'(q.avg_k));
  end

  // ==========================================================================
  // Frequency steering
  always_comb
  begin
    ramp_load = 1'b0;
    ramp_run = 1'b0;
    ramp_val = '0;
    ramp_target = LOOP_FREQ_I;
    case (q.mode)
      MODE_ACQ, MODE_LOCKED:
      begin
        if (q.ho_ramp)
          ramp_run = 1'b1;
        else
        begin
          ramp_load = 1'b1;
          ramp_val = LOOP_FREQ_I;
        end
      end
      MODE_HOLD:
      begin
        ramp_run = !q.avg_busy;
        ramp_target = q.hold_freq;
      end
      MODE_FREEZE:
      begin
        ramp_load = 1'b1;
        ramp_val = q.last_freq;
      end
      default:
      begin
        // nominal word, accuracy follows the crystal
        ramp_load = 1'b1;
      end
    endcase
  end

  // ==========================================================================
  // Main state
  always_comb
  begin
    n = q;
    n.rst_sync = {q.rst_sync[0], HARD_RESET_N_PIN_I};
    n.rdata = '0;
    n.nvm_rd = 1'b0;
    n.nvm_pend = q.nvm_rd;
    n.cap_addr = q.nvm_addr;
    n.hist_cnt = hist_tick ? '0 : (q.init_done ? q.hist_cnt + 32'h1 : '0);
    n.ramp_cnt = ramp_tick ? '0 : (q.init_done ? q.ramp_cnt + 8'h1 : '0);
    acc_n = q.acc + (FREQ_W + 7)'(hb.rdata);
    if (q.mode == MODE_INIT)
    begin
      // load every word from the store first
      if (q.nvm_pend)
      begin
        n.act = cfg_put(q.act, q.cap_addr, NVM_DATA_I);
        n.pend = cfg_put(q.pend, q.cap_addr, NVM_DATA_I);
      end
      if (q.nvm_idx < `NVM_WORDS)
      begin
        n.nvm_rd = 1'b1;
        n.nvm_addr = q.nvm_idx[1:0];
        n.nvm_idx = q.nvm_idx + 3'h1;
      end
      else if (!q.nvm_rd && !q.nvm_pend)
      begin
        n.mode = MODE_FREERUN;
        n.init_done = 1'b1;
      end
    end
    else
    begin
      if (REG_WR_I && REG_ADDR_I < 3'h4)
      begin
        n.pend = cfg_put(q.pend, REG_ADDR_I[1:0], wr_word);
        if (REG_ADDR_I == `REG_CTRL && wr_word[`CTRL_SOFT_BIT])
          n.act = n.pend;
      end
      if (REG_RD_I)
      begin
        if (REG_ADDR_I < 3'h4)
          n.rdata = cfg_get(q.pend, REG_ADDR_I[1:0]);
        else if (REG_ADDR_I == `REG_STATUS)
          n.rdata = {10'h000, q.init_done, q.hist_valid, q.loss_of_lock_indicator, q.mode};
        else if (REG_ADDR_I == `REG_FREQ_LO)
          n.rdata = q.freq_out[15:0];
        else if (REG_ADDR_I == `REG_FREQ_HI)
          n.rdata = 16'(q.freq_out >> 16);
        else
          n.rdata = '0;
      end
      if (hb.we)
      begin
        n.wptr = q.wptr + AW'(1);
        if (q.filled < (AW + 1)'(HIST_DEPTH))
          n.filled = q.filled + (AW + 1)'(1);
      end
      // enough samples for window plus delay
      n.hist_valid = 8'(n.filled) >= 8'(win_n) + 8'(delay);
      if (q.mode == MODE_ACQ || q.mode == MODE_LOCKED)
      begin
        if (sel_valid)
          n.last_freq = LOOP_FREQ_I;
        if (q.ho_ramp && ramp_done)
          n.ho_ramp = 1'b0;
      end
      if (q.avg_busy)
      begin
        if (q.avg_k != 7'h00)
          n.acc = acc_n;
        if (q.avg_k == win_n)
        begin
          n.avg_busy = 1'b0;
          n.hold_freq = FREQ_W'(acc_n >> win);
        end
        else
          n.avg_k = q.avg_k + 7'h01;
      end
      case (q.mode)
        MODE_FREERUN:
        begin
          if (any_valid)
            n.mode = MODE_ACQ;
        end
        MODE_ACQ, MODE_LOCKED:
        begin
          if (!any_valid)
          begin
            n.ho_ramp = 1'b0;
            n.ho_exit = 1'b0;
            if (q.hist_valid)
            begin
              n.mode = MODE_HOLD;
              n.avg_busy = 1'b1;
              n.avg_k = '0;
              n.acc = '0;
            end
            else
              n.mode = MODE_FREEZE;
          end
          else if (q.mode == MODE_ACQ && LOCK_DET_I && sel_valid && !q.ho_ramp)
          begin
            n.mode = MODE_LOCKED;
            n.ho_exit = 1'b0;
          end
          else if (q.mode == MODE_LOCKED && (!LOCK_DET_I || !sel_valid))
            n.mode = MODE_ACQ;
        end
        MODE_HOLD:
        begin
          // leave holdover on a valid input
          if (any_valid && !q.avg_busy)
          begin
            n.mode = MODE_ACQ;
            n.ho_ramp = q.act.ctrl[`CTRL_RAMP_BIT];
            n.ho_exit = !q.act.ctrl[`CTRL_RAMP_BIT];
          end
        end
        MODE_FREEZE:
        begin
          if (any_valid)
            n.mode = MODE_ACQ;
        end
        default:
        begin
          n.mode = MODE_FREERUN;
        end
      endcase
    end
    // Bandwidth is chosen from the next mode so that it changes with the mode itself.
    n.bw = bw_norm;
    if (n.mode == MODE_ACQ)
    begin
      if (n.ho_exit)
        n.bw = q.act.ctrl[`CTRL_HOSEL_BIT] ? bw_hoex : bw_norm;
      else if (q.act.ctrl[`CTRL_FAST_BIT])
        n.bw = bw_fast;
    end
    n.loss_of_lock_indicator = (n.mode != MODE_LOCKED);
    n.freq_out = ramp_freq;
    if (hard_req)
    begin
      n = '0;
      n.loss_of_lock_indicator = 1'b1;
      n.rst_sync = {q.rst_sync[0], HARD_RESET_N_PIN_I};
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      q <= '0;
      q.loss_of_lock_indicator <= 1'b1;
      q.rst_sync <= 2'b11;
    end
    else
      q <= n;
  end

  // ==========================================================================
  // Submodules
  hist_mem #(.W(FREQ_W), .DEPTH(HIST_DEPTH), .AW(AW)) u_hist (
    .clk_i(REF_CLK_I),
    .port(hb.mem)
  );

  freq_ramp #(.W(FREQ_W)) u_ramp (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .tick_i(ramp_tick),
    .load_i(ramp_load),
    .load_val_i(ramp_val),
    .run_i(ramp_run),
    .target_i(ramp_target),
    .step_i(ramp_step),
    .freq_o(ramp_freq),
    .at_target_o(ramp_done)
  );

  // ==========================================================================
  // Outputs
  assign NVM_RD_O = q.nvm_rd;
  assign NVM_ADDR_O = q.nvm_addr;
  assign REG_RDATA_O = q.rdata;
  assign LOOP_MODE_O = q.mode;
  assign BW_CODE_O = q.bw;
  assign FREQ_WORD_O = q.freq_out;
  // no output clocks before start-up ends
  assign OUT_CLK_EN_O = q.init_done;
  // lock shown on pin and status bit
  assign LOSS_OF_LOCK_INDICATOR_O = q.loss_of_lock_indicator;
  assign HIST_VALID_O = q.hist_valid;
endmodule

/* tb/nvm_model.sv */
/*
  Behavioural nonvolatile configuration store on the start-up load port.
  Assumes one word strobe per rising clock edge and data sampled one edge later.
*/
module nvm_model (
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [1:0] addr_i,
  input wire logic [15:0] image_i [4],
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Read port
  // word per strobe
  // Outside a read the bus shows the inverse, so a late sample is caught.
  always_ff @(posedge clk_i)
    data_o <= rd_i ? image_i[addr_i] : ~data_o;
endmodule

/* tb/synth_loop_mode_controller_monitor.sv */
/*
  Port checker of the loop mode controller, bound to its top module.
  Assumes one reference clock and the bandwidth clamps of the high loop.
*/
`include "loop_ctl_defs.svh"
module synth_loop_mode_controller_monitor #(
  parameter int unsigned FREQ_W = 24
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic HARD_RESET_N_PIN_I,
  input wire logic NVM_RD_O,
  input wire logic [1:0] NVM_ADDR_O,
  input wire logic [15:0] NVM_DATA_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic [3:0] INPUT_VALID_I,
  input wire logic [1:0] SEL_INPUT_I,
  input wire logic LOCK_DET_I,
  input wire logic [FREQ_W-1:0] LOOP_FREQ_I,
  input wire loop_ctl_pkg::mode_t LOOP_MODE_O,
  input wire logic [3:0] BW_CODE_O,
  input wire logic [FREQ_W-1:0] FREQ_WORD_O,
  input wire logic OUT_CLK_EN_O,
  input wire logic LOSS_OF_LOCK_INDICATOR_O,
  input wire logic HIST_VALID_O
);
  timeunit 1ns;
  timeprecision 1ps;
  import loop_ctl_pkg::*;
  logic [3:0] pause_q;
  logic [3:0] pause_d;
  logic hard_wr;
  // ==========================================================================
  // Pause after the hard reset bit
  // That reload restarts start-up without RST_I, so the checks rest meanwhile.
  assign hard_wr = REG_WR_I && REG_ADDR_I == `REG_CTRL && REG_WDATA_I[`CTRL_HARD_BIT];
  assign pause_d = hard_wr ? 4'hf : pause_q - 4'(pause_q != 4'h0);
  always_ff @(posedge REF_CLK_I)
    pause_q <= RST_I ? 4'h0 : pause_d;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I || !HARD_RESET_N_PIN_I || pause_q != 4'h0);
  // ==========================================================================
  // Properties
  a_mode_legal: assert property (
    LOOP_MODE_O inside {MODE_INIT, MODE_FREERUN, MODE_ACQ, MODE_LOCKED, MODE_HOLD, MODE_FREEZE})
    else $error("mode code out of range");
  a_lol_mode: assert property (
    LOSS_OF_LOCK_INDICATOR_O == (LOOP_MODE_O != MODE_LOCKED))
    else $error("loss of lock disagrees with mode");
  a_init_quiet: assert property (
    LOOP_MODE_O == MODE_INIT |-> !OUT_CLK_EN_O)
    else $error("clocks enabled during start-up");
  a_init_refuse: assert property (
    REG_RD_I && LOOP_MODE_O == MODE_INIT |=> REG_RDATA_O == 16'h0000)
    else $error("read answered during start-up");
  a_store_burst: assert property (
    $rose(NVM_RD_O) |-> NVM_ADDR_O == 2'h0 ##1 (NVM_RD_O && NVM_ADDR_O == 2'h1)
      ##1 (NVM_RD_O && NVM_ADDR_O == 2'h2) ##1 (NVM_RD_O && NVM_ADDR_O == 2'h3) ##1 !NVM_RD_O)
    else $error("store load out of order");
  a_idle_exit: assert property (
    LOOP_MODE_O == MODE_FREERUN || LOOP_MODE_O == MODE_FREEZE
    |=> LOOP_MODE_O == ($past(|INPUT_VALID_I) ? MODE_ACQ : $past(LOOP_MODE_O)))
    else $error("wrong move from an idle mode");
  a_lock_lost: assert property (
    LOOP_MODE_O == MODE_LOCKED && |INPUT_VALID_I && !(LOCK_DET_I && INPUT_VALID_I[SEL_INPUT_I])
    |=> LOOP_MODE_O == MODE_ACQ)
    else $error("lost lock not back to acquisition");
  a_input_lost: assert property (
    (LOOP_MODE_O == MODE_ACQ || LOOP_MODE_O == MODE_LOCKED) && INPUT_VALID_I == 4'h0
    |=> LOOP_MODE_O == ($past(HIST_VALID_O) ? MODE_HOLD : MODE_FREEZE))
    else $error("wrong mode after inputs lost");
  a_freeze_still: assert property (
    (LOOP_MODE_O == MODE_FREEZE && INPUT_VALID_I == 4'h0)[*4] |=> $stable(FREQ_WORD_O))
    else $error("frozen word moved");
  a_bw_range: assert property (
    (LOOP_MODE_O != MODE_INIT)[*2] |-> BW_CODE_O inside {[4'h3:4'hc]})
    else $error("bandwidth code out of range");
endmodule
bind synth_loop_mode_controller synth_loop_mode_controller_monitor #(.FREQ_W(FREQ_W)) mon_inst (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .HARD_RESET_N_PIN_I(HARD_RESET_N_PIN_I),
  .NVM_RD_O(NVM_RD_O), .NVM_ADDR_O(NVM_ADDR_O), .NVM_DATA_I(NVM_DATA_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .INPUT_VALID_I(INPUT_VALID_I),
  .SEL_INPUT_I(SEL_INPUT_I), .LOCK_DET_I(LOCK_DET_I), .LOOP_FREQ_I(LOOP_FREQ_I),
  .LOOP_MODE_O(LOOP_MODE_O), .BW_CODE_O(BW_CODE_O), .FREQ_WORD_O(FREQ_WORD_O),
  .OUT_CLK_EN_O(OUT_CLK_EN_O), .LOSS_OF_LOCK_INDICATOR_O(LOSS_OF_LOCK_INDICATOR_O),
  .HIST_VALID_O(HIST_VALID_O));

/* tb/tb.sv */
/*
  Self-checking bench of the loop mode controller with a store model.
  Assumes the checker is bound to the design; history ticks are shortened.
*/
`include "loop_ctl_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import loop_ctl_pkg::*;
  localparam int unsigned TICK = 20;
  logic clk, rst, pin_n, nvm_rd, reg_wr, reg_rd, lock, clk_en, loss_of_lock_indicator, hist;
  logic [1:0] nvm_addr, sel;
  logic [2:0] reg_addr;
  logic [3:0] valid, bw, nb, fb, eb;
  logic [15:0] nvm_data, reg_wdata, reg_rdata;
  logic [15:0] image [4];
  logic [23:0] lfreq, fword, f, g, a;
  mode_t mode;
  int errors, n_tests, k, seed;
  // ==========================================================================
  // Clock and parts
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  synth_loop_mode_controller #(.HIST_TICK_CYC(TICK)) synth_loop_mode_controller_inst (
    .REF_CLK_I(clk), .RST_I(rst), .HARD_RESET_N_PIN_I(pin_n), .NVM_RD_O(nvm_rd),
    .NVM_ADDR_O(nvm_addr), .NVM_DATA_I(nvm_data), .REG_ADDR_I(reg_addr),
    .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata),
    .INPUT_VALID_I(valid), .SEL_INPUT_I(sel), .LOCK_DET_I(lock), .LOOP_FREQ_I(lfreq),
    .LOOP_MODE_O(mode), .BW_CODE_O(bw), .FREQ_WORD_O(fword), .OUT_CLK_EN_O(clk_en),
    .LOSS_OF_LOCK_INDICATOR_O(loss_of_lock_indicator), .HIST_VALID_O(hist));
  nvm_model nvm_model_inst (.clk_i(clk), .rd_i(nvm_rd), .addr_i(nvm_addr), .image_i(image),
    .data_o(nvm_data));
  // ==========================================================================
  // Tasks
  task automatic finish_test();
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] ad, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] ad, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg%0d", ad), {8'h00, reg_rdata}, {8'h00, e});
  endtask
  function automatic logic [23:0] step_of(input logic [5:0] r);
    return (24'd2 + 24'(r[0])) << r[5:1];
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_mode(input mode_t m);
    for (int i = 0; i < 600 && mode !== m; i++)
      @(negedge clk);
    chk("mode", 24'(mode), 24'(m));
  endtask
  task automatic wait_en();
    for (int i = 0; i < 100 && clk_en !== 1'b1; i++)
      @(negedge clk);
    chk("clk_en", 24'(clk_en), 24'h1);
  endtask
  task automatic drive(input logic [3:0] v, input logic [1:0] s, input logic l,
                       input logic [23:0] fr);
    @(posedge clk);
    valid <= v;
    sel <= s;
    lock <= l;
    lfreq <= fr;
  endtask
  // ==========================================================================
  // Timeout
  initial
  begin
    for (int c = 0; c < 20000; c++)
      @(posedge clk);
    errors++;
    finish_test();
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    image = '{16'h0003, 16'h0496, 16'h0081, 16'h0008};
    {rst, pin_n, reg_wr, reg_rd, lock, reg_addr, reg_wdata, valid, sel, lfreq} = '0;
    rst = 1'b1;
    pin_n = 1'b1;
    errors = 0;
    n_tests = 0;
    seed = $urandom(8);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(`REG_STATUS, 16'h0000);
    wait_en();
    wait_mode(MODE_FREERUN);
    for (int i = 0; i < 4; i++)
      rdc(3'(i), image[i]);
    rdc(3'h7, 16'h0000);
    wr(`REG_STATUS, 16'hffff);
    rdc(`REG_STATUS, 16'h0029);
    nb = 4'(3 + $urandom % 10);
    fb = 4'(5 + $urandom % 8);
    eb = 4'(3 + $urandom % 10);
    f = 24'($urandom % 24'h800000);
    wr(`REG_BW, {4'h0, eb, fb, nb});
    cyc(2);
    chk("bw", 24'(bw), 24'(image[1][3:0]));
    wr(`REG_CTRL, 16'h000b);
    cyc(2);
    chk("bw", 24'(bw), 24'(nb));
    drive(4'h1, 2'h0, 1'b0, f);
    wait_mode(MODE_ACQ);
    cyc(3);
    chk("bw", 24'(bw), 24'(fb));
    chk("freq", fword, f);
    drive(4'h1, 2'h0, 1'b1, f);
    wait_mode(MODE_LOCKED);
    cyc(2);
    chk("bw", 24'(bw), 24'(nb));
    chk("hist", 24'(hist), 24'h0);
    rdc(`REG_FREQ_LO, f[15:0]);
    rdc(`REG_FREQ_HI, {8'h00, f[23:16]});
    for (k = 0; k < 400 && hist !== 1'b1; k++)
      cyc(1);
    chk("hist_wait", 24'(k >= 4 * TICK && k <= 7 * TICK), 24'h1);
    drive(4'h0, 2'h0, 1'b1, f);
    wait_mode(MODE_HOLD);
    cyc(40);
    chk("freq", fword, f);
    g = f + 24'd320;
    drive(4'h2, 2'h1, 1'b1, g);
    wait_mode(MODE_ACQ);
    cyc(60);
    a = fword;
    cyc(40);
    chk("ramp_step", fword - a, step_of(image[3][5:0]));
    wait_mode(MODE_LOCKED);
    cyc(3);
    chk("freq", fword, g);
    wr(`REG_CTRL, 16'h000c);
    drive(4'h0, 2'h1, 1'b0, g);
    wait_mode(MODE_HOLD);
    cyc(10);
    drive(4'h2, 2'h1, 1'b0, g);
    wait_mode(MODE_ACQ);
    cyc(2);
    chk("bw", 24'(bw), 24'(eb));
    @(posedge clk);
    pin_n <= 1'b0;
    cyc(8);
    @(posedge clk);
    pin_n <= 1'b1;
    valid <= 4'h0;
    wait_en();
    chk("hist", 24'(hist), 24'h0);
    rdc(`REG_BW, image[1]);
    drive(4'h1, 2'h0, 1'b1, f);
    wait_mode(MODE_LOCKED);
    drive(4'h0, 2'h0, 1'b1, ~f);
    wait_mode(MODE_FREEZE);
    cyc(6);
    chk("freq", fword, f);
    drive(4'h4, 2'h2, 1'b0, f);
    wait_mode(MODE_ACQ);
    drive(4'h0, 2'h2, 1'b0, f);
    wr(`REG_BW, 16'h0555);
    wr(`REG_CTRL, 16'h0010);
    wait_mode(MODE_INIT);
    wait_en();
    rdc(`REG_BW, image[1]);
    finish_test();
  end
endmodule
